// File: verilog/jtag_tap_boundary_scan.sv
// Test access port, instruction, bypass and boundary-scan registers.
// Assumes the test pins are asynchronous and sampled on the system clock.
// Notes on behaviour
// - A three-bit instruction register selects the instruction and the data register.
// - External test shifts the chain, then drives its held values onto pins.
// - Sample/preload captures live pins for shifting out and allows preloading.
// - Tristate floats host bus and serial ROM pads; other ports run on.
// - Code 6 selects continuity mode, flagged on an output.
// - Bypass code routes serial data through the one-bit bypass register.
// - Under bypass the pads carry the functional values unchanged.
// - Reset brings the controller to its reset state with bypass active.
// - Single-stage bypass register serves whenever the chain is not selected.
// - Chain cells observe and control the host, ROM, port and MII pads.
// - Output-enable cells drive their pads from the chain during external test.
// - Cells are chained in fixed order from interrupt pin to management enable.
// - Two internal cells sit in the ring with no pad behind them.
// - Full sixteen-state controller advanced by mode select on test clock rises.
// - Controller sequences capture and shift of every register, and update of the instruction and chain registers.
`default_nettype none
module jtag_tap_boundary_scan (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [jtag_pkg::CHAIN_LEN-1:0] PAD_IN,
  input wire logic [jtag_pkg::CHAIN_LEN-1:0] CORE_PAD_OUT,
  output logic [jtag_pkg::CHAIN_LEN-1:0] PAD_OUT,
  output logic PADS_FLOAT,
  output logic CONTINUITY_MODE,
  output logic [jtag_pkg::IR_WIDTH-1:0] ACTIVE_INSTR
);
  tap_pins_if pins ();
  jtag_pkg::tap_state_e state_reg;
  jtag_pkg::tap_state_e state_next;
  logic [jtag_pkg::IR_WIDTH-1:0] ir_shift_reg;
  logic [jtag_pkg::IR_WIDTH-1:0] instr_code;
  logic bypass_reg;
  logic [jtag_pkg::CHAIN_LEN-1:0] bsr_shift_reg;
  logic [jtag_pkg::CHAIN_LEN-1:0] bsr_hold_reg;
  logic [jtag_pkg::CHAIN_LEN-1:0] pad_out_reg;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic float_reg;
  logic cont_reg;
  logic bsr_sel;
  logic extest_on;

  tap_pin_sync u_sync (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .tck(TCK),
    .tms(TMS),
    .tdi(TDI),
    .pins(pins)
  );

  // Only codes 0 and 1 put the chain between serial input and output.
  assign bsr_sel = (instr_code == jtag_pkg::INSTR_EXTEST) ||
                   (instr_code == jtag_pkg::INSTR_SAMPLE);
  assign extest_on = (instr_code == jtag_pkg::INSTR_EXTEST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      jtag_pkg::TAP_RESET: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_RESET;
        end else begin
          state_next = jtag_pkg::TAP_IDLE;
        end
      end
      jtag_pkg::TAP_IDLE: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_SEL_DR;
        end else begin
          state_next = jtag_pkg::TAP_IDLE;
        end
      end
      jtag_pkg::TAP_SEL_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_SEL_IR;
        end else begin
          state_next = jtag_pkg::TAP_CAP_DR;
        end
      end
      jtag_pkg::TAP_CAP_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_EX1_DR;
        end else begin
          state_next = jtag_pkg::TAP_SH_DR;
        end
      end
      jtag_pkg::TAP_SH_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_EX1_DR;
        end else begin
          state_next = jtag_pkg::TAP_SH_DR;
        end
      end
      jtag_pkg::TAP_EX1_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_UPD_DR;
        end else begin
          state_next = jtag_pkg::TAP_PAU_DR;
        end
      end
      jtag_pkg::TAP_PAU_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_EX2_DR;
        end else begin
          state_next = jtag_pkg::TAP_PAU_DR;
        end
      end
      jtag_pkg::TAP_EX2_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_UPD_DR;
        end else begin
          state_next = jtag_pkg::TAP_SH_DR;
        end
      end
      jtag_pkg::TAP_UPD_DR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_SEL_DR;
        end else begin
          state_next = jtag_pkg::TAP_IDLE;
        end
      end
      jtag_pkg::TAP_SEL_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_RESET;
        end else begin
          state_next = jtag_pkg::TAP_CAP_IR;
        end
      end
      jtag_pkg::TAP_CAP_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_EX1_IR;
        end else begin
          state_next = jtag_pkg::TAP_SH_IR;
        end
      end
      jtag_pkg::TAP_SH_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_EX1_IR;
        end else begin
          state_next = jtag_pkg::TAP_SH_IR;
        end
      end
      jtag_pkg::TAP_EX1_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_UPD_IR;
        end else begin
          state_next = jtag_pkg::TAP_PAU_IR;
        end
      end
      jtag_pkg::TAP_PAU_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_EX2_IR;
        end else begin
          state_next = jtag_pkg::TAP_PAU_IR;
        end
      end
      jtag_pkg::TAP_EX2_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_UPD_IR;
        end else begin
          state_next = jtag_pkg::TAP_SH_IR;
        end
      end
      jtag_pkg::TAP_UPD_IR: begin
        if (pins.tms) begin
          state_next = jtag_pkg::TAP_SEL_DR;
        end else begin
          state_next = jtag_pkg::TAP_IDLE;
        end
      end
      // All sixteen codes are states, so this only catches unknowns and falls back to reset.
      default: begin
        state_next = jtag_pkg::TAP_RESET;
      end
    endcase
  end

  // The controller moves only on a test clock rise, as the tester sees it.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_reg <= jtag_pkg::TAP_RESET;
    end else if (pins.tck_rise) begin
      state_reg <= state_next;
    end
  end

  // Capture and shift happen on the rise that leaves the capture or shift state.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ir_shift_reg <= jtag_pkg::IR_CAPTURE_VALUE;
    end else if (pins.tck_rise) begin
      if (state_reg == jtag_pkg::TAP_CAP_IR) begin
        ir_shift_reg <= jtag_pkg::IR_CAPTURE_VALUE;
      end else if (state_reg == jtag_pkg::TAP_SH_IR) begin
        ir_shift_reg <= {pins.tdi, ir_shift_reg[jtag_pkg::IR_WIDTH-1:1]};
      end
    end
  end

  // The bypass stage captures zero, so a tester can count the devices in a ring.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      bypass_reg <= 1'b0;
    end else if (pins.tck_rise && !bsr_sel) begin
      if (state_reg == jtag_pkg::TAP_CAP_DR) begin
        bypass_reg <= 1'b0;
      end else if (state_reg == jtag_pkg::TAP_SH_DR) begin
        bypass_reg <= pins.tdi;
      end
    end
  end

  // Internal cells keep their own value on capture since no pad stands behind them.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      bsr_shift_reg <= '0;
    end else if (pins.tck_rise && bsr_sel) begin
      if (state_reg == jtag_pkg::TAP_CAP_DR) begin
        bsr_shift_reg <= (PAD_IN & ~jtag_pkg::INTERNAL_MASK) |
                         (bsr_shift_reg & jtag_pkg::INTERNAL_MASK);
      end else if (state_reg == jtag_pkg::TAP_SH_DR) begin
        bsr_shift_reg <= {bsr_shift_reg[jtag_pkg::CHAIN_LEN-2:0], pins.tdi};
      end
    end
  end

  // Updates land on the falling test clock so held values never ripple while shifting.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      instr_code <= jtag_pkg::INSTR_BYPASS;
    end else if (state_reg == jtag_pkg::TAP_RESET) begin
      instr_code <= jtag_pkg::INSTR_BYPASS;
    end else if (pins.tck_fall && state_reg == jtag_pkg::TAP_UPD_IR) begin
      instr_code <= ir_shift_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      bsr_hold_reg <= '0;
    end else if (pins.tck_fall && bsr_sel && state_reg == jtag_pkg::TAP_UPD_DR) begin
      bsr_hold_reg <= bsr_shift_reg;
    end
  end

  // Serial output changes on the falling test clock, driven only while shifting.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (pins.tck_fall) begin
      tdo_oe_reg <= (state_reg == jtag_pkg::TAP_SH_DR) ||
                    (state_reg == jtag_pkg::TAP_SH_IR);
      if (state_reg == jtag_pkg::TAP_SH_IR) begin
        tdo_reg <= ir_shift_reg[0];
      end else if (bsr_sel) begin
        tdo_reg <= bsr_shift_reg[jtag_pkg::IDX_MDIO_OE];
      end else begin
        tdo_reg <= bypass_reg;
      end
    end
  end

  // Pad values and enables pass through one register; internal cells drive nothing.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      pad_out_reg <= '0;
    end else if (extest_on) begin
      pad_out_reg <= bsr_hold_reg & ~jtag_pkg::INTERNAL_MASK;
    end else begin
      pad_out_reg <= CORE_PAD_OUT & ~jtag_pkg::INTERNAL_MASK;
    end
  end

  // Tristate only raises the flag; the pad ring floats the pads, so pad values stay functional.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      float_reg <= 1'b0;
      cont_reg <= 1'b0;
    end else begin
      float_reg <= (instr_code == jtag_pkg::INSTR_TRISTATE);
      cont_reg <= (instr_code == jtag_pkg::INSTR_CONTINUITY);
    end
  end

  assign TDO = tdo_reg;
  assign TDO_OE = tdo_oe_reg;
  assign PAD_OUT = pad_out_reg;
  assign PADS_FLOAT = float_reg;
  assign CONTINUITY_MODE = cont_reg;
  assign ACTIVE_INSTR = instr_code;
endmodule
`default_nettype wire

// File: verilog/jtag_pkg.sv
// Constants, state codes and chain layout for the boundary-scan test logic.
// Assumes nothing beyond a SystemVerilog compiler; every user names it in full.
`default_nettype none
package jtag_pkg;
  localparam int IR_WIDTH = 3;
  localparam int CHAIN_LEN = 109;
  localparam int TAP_STATE_WIDTH = 4;
  localparam int SYNC_STAGES = 2;
  localparam int TCK_PERIOD_NS = 160;
  localparam int SYS_PERIOD_NS = 20;
  // System clocks per test clock; each test clock half must span at least three.
  localparam int TCK_CYCLES = TCK_PERIOD_NS / SYS_PERIOD_NS;

  localparam logic [2:0] INSTR_EXTEST = 3'h0;
  localparam logic [2:0] INSTR_SAMPLE = 3'h1;
  localparam logic [2:0] INSTR_RSVD_2 = 3'h2;
  localparam logic [2:0] INSTR_RSVD_3 = 3'h3;
  localparam logic [2:0] INSTR_RSVD_4 = 3'h4;
  localparam logic [2:0] INSTR_TRISTATE = 3'h5;
  localparam logic [2:0] INSTR_CONTINUITY = 3'h6;
  localparam logic [2:0] INSTR_BYPASS = 3'h7;
  // Value loaded into the instruction shift stage on capture; low bits 01.
  localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;

  // Chain index 0 sits next to serial input, the last index next to serial output.
  localparam int IDX_INTERRUPT = 0;
  localparam int IDX_INTERNAL_A = 59;
  localparam int IDX_INTERNAL_B = 82;
  localparam int IDX_MDIO_OE = 108;
  localparam logic [CHAIN_LEN-1:0] ONE_BIT = {{(CHAIN_LEN-1){1'b0}}, 1'b1};
  localparam logic [CHAIN_LEN-1:0] INTERNAL_MASK =
    (ONE_BIT << IDX_INTERNAL_A) | (ONE_BIT << IDX_INTERNAL_B);

  typedef enum logic [TAP_STATE_WIDTH-1:0] {
    TAP_RESET = 4'hF,
    TAP_IDLE = 4'hC,
    TAP_SEL_DR = 4'h7,
    TAP_CAP_DR = 4'h6,
    TAP_SH_DR = 4'h2,
    TAP_EX1_DR = 4'h1,
    TAP_PAU_DR = 4'h3,
    TAP_EX2_DR = 4'h0,
    TAP_UPD_DR = 4'h5,
    TAP_SEL_IR = 4'h4,
    TAP_CAP_IR = 4'hE,
    TAP_SH_IR = 4'hA,
    TAP_EX1_IR = 4'h9,
    TAP_PAU_IR = 4'hB,
    TAP_EX2_IR = 4'h8,
    TAP_UPD_IR = 4'hD
  } tap_state_e;
endpackage
`default_nettype wire

// File: verilog/tap_pins_if.sv
// Carries the synchronised test pins and test clock edge strobes.
// Assumes both ends run on the same system clock.
`default_nettype none
interface tap_pins_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  modport sync (output tck_rise, output tck_fall, output tms, output tdi);
  modport tap (input tck_rise, input tck_fall, input tms, input tdi);
endinterface
`default_nettype wire

// File: verilog/tap_pin_sync.sv
// Two-stage synchroniser for the test pins, with test clock edge detection.
// Assumes the test clock runs well below a third of the system clock rate.
`default_nettype none
module tap_pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  tap_pins_if.sync pins
);
  logic [2:0] meta_reg;
  logic [2:0] stable_reg;
  logic tck_last_reg;

  // Only the second stage reads the first; all logic looks at the second.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= 3'h0;
      stable_reg <= 3'h0;
      tck_last_reg <= 1'b0;
    end else begin
      meta_reg <= {tdi, tms, tck};
      stable_reg <= meta_reg;
      tck_last_reg <= stable_reg[0];
    end
  end

  assign pins.tck_rise = stable_reg[0] & ~tck_last_reg;
  assign pins.tck_fall = ~stable_reg[0] & tck_last_reg;
  assign pins.tms = stable_reg[1];
  assign pins.tdi = stable_reg[2];
endmodule
`default_nettype wire

// File: verif/jtag_tap_boundary_scan_monitor.sv
// Port checker for the boundary-scan block.
// Assumes each test clock half spans at least three system clocks.
`default_nettype none
module jtag_tap_boundary_scan_monitor (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic [jtag_pkg::CHAIN_LEN-1:0] PAD_IN,
  input wire logic [jtag_pkg::CHAIN_LEN-1:0] CORE_PAD_OUT,
  input wire logic [jtag_pkg::CHAIN_LEN-1:0] PAD_OUT,
  input wire logic PADS_FLOAT,
  input wire logic CONTINUITY_MODE,
  input wire logic [jtag_pkg::IR_WIDTH-1:0] ACTIVE_INSTR
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_rst;
    $rose(RESET_N) |-> ACTIVE_INSTR == jtag_pkg::INSTR_BYPASS && !TDO_OE && !TDO;
  endproperty
  a_rst: assert property (p_rst) else $error("no bypass after reset");
  property p_flt;
    PADS_FLOAT == ($past(ACTIVE_INSTR) == jtag_pkg::INSTR_TRISTATE);
  endproperty
  a_flt: assert property (p_flt) else $error("float flag wrong");
  property p_cnt;
    CONTINUITY_MODE == ($past(ACTIVE_INSTR) == jtag_pkg::INSTR_CONTINUITY);
  endproperty
  a_cnt: assert property (p_cnt) else $error("continuity flag wrong");
  property p_int;
    (PAD_OUT & jtag_pkg::INTERNAL_MASK) == '0;
  endproperty
  a_int: assert property (p_int) else $error("internal cell drives pad");
  property p_fun;
    ACTIVE_INSTR != jtag_pkg::INSTR_EXTEST
      |=> PAD_OUT == ($past(CORE_PAD_OUT) & ~jtag_pkg::INTERNAL_MASK);
  endproperty
  a_fun: assert property (p_fun) else $error("pads disturbed");
  property p_ins;
    $changed(ACTIVE_INSTR) |-> !TDO_OE &&
      (!$past(TCK, 2) || ACTIVE_INSTR == jtag_pkg::INSTR_BYPASS);
  endproperty
  a_ins: assert property (p_ins) else $error("instruction changed off update");
  property p_tdo;
    $changed(TDO) |-> !$past(TCK, 2);
  endproperty
  a_tdo: assert property (p_tdo) else $error("serial out moved off a fall");
  property p_ext;
    $changed(PAD_OUT) && $past(ACTIVE_INSTR) == jtag_pkg::INSTR_EXTEST
      && ACTIVE_INSTR == jtag_pkg::INSTR_EXTEST |-> !$past(TCK, 2);
  endproperty
  a_ext: assert property (p_ext) else $error("test pads moved off update");
  c_ext: cover property (ACTIVE_INSTR == jtag_pkg::INSTR_EXTEST);
  c_flt: cover property (PADS_FLOAT);
  c_sh: cover property (TDO_OE ##1 TDO_OE);
endmodule
bind jtag_tap_boundary_scan jtag_tap_boundary_scan_monitor jtag_tap_boundary_scan_monitor_inst (
  .SYS_CLK, .RESET_N, .TCK, .TMS, .TDI, .TDO, .TDO_OE, .PAD_IN, .CORE_PAD_OUT,
  .PAD_OUT, .PADS_FLOAT, .CONTINUITY_MODE, .ACTIVE_INSTR);
`default_nettype wire

// File: verif/tap_tester.sv
// Behavioural test controller that drives the test pins.
// Assumes clk is the system clock; the test clock rests low between frames.
`default_nettype none
module tap_tester (
  input wire logic clk,
  input wire logic tdo,
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {tck, tms, tdi} = 3'b011;
  // Five clocks low, three high: the answer to a fall settles before it is read.
  task automatic cyc(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1 tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1 q = tdo;
    tck = 1'b1;
    repeat (3) @(posedge clk);
    #1 tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/test_jtag_tap_boundary_scan.sv
// Self-checking bench for the boundary-scan block.
// Assumes the package, the monitor and the test controller compile first.
`default_nettype none
module test_jtag_tap_boundary_scan;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = jtag_pkg::CHAIN_LEN;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, pads_float, continuity_mode, q;
  logic [N-1:0] pad_in, core_pad_out, pad_out, pre_pat;
  logic [2:0] active_instr;
  logic [127:0] sh_out, din, msk, exp_v;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  always #10 sys_clk = ~sys_clk;
  jtag_tap_boundary_scan jtag_tap_boundary_scan_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .PAD_IN(pad_in),
    .CORE_PAD_OUT(core_pad_out), .PAD_OUT(pad_out), .PADS_FLOAT(pads_float),
    .CONTINUITY_MODE(continuity_mode), .ACTIVE_INSTR(active_instr));
  tap_tester tap_tester_inst (.clk(sys_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic cyc(input logic m, input logic d);
    tap_tester_inst.cyc(m, d, q);
  endtask
  task automatic load_ir(input logic [2:0] code);
    for (int i = 0; i < 4; i++) cyc(i < 2, 1'b0);
    for (int i = 0; i < 3; i++) begin
      cyc(i == 2, code[i]);
      chk("ir capture", q, jtag_pkg::IR_CAPTURE_VALUE[i]);
    end
    cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    chk("instr", active_instr, code);
  endtask
  task automatic shift_dr(input int n);
    sh_out = '0;
    for (int i = 0; i < 3; i++) cyc(i == 0, 1'b0);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i]);
      sh_out[i] = q;
    end
    cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic t_bypass();
    cyc(1'b0, 1'b0);
    for (int c = 2; c < 8; c++) begin
      load_ir(3'(c));
      din = 128'hB;
      shift_dr(4);
      chk("bypass out", sh_out, 128'h6);
      chk("float", pads_float, c == 5);
      chk("continuity", continuity_mode, c == 6);
      chk("pads", pad_out, core_pad_out & ~jtag_pkg::INTERNAL_MASK);
    end
  endtask
  task automatic t_chain();
    load_ir(jtag_pkg::INSTR_SAMPLE);
    for (int k = 0; k < 128; k++) begin
      din[k] = (k < N) ? pre_pat[N-1-k] : 1'b0;
      exp_v[k] = (k < N) ? pad_in[N-1-k] : 1'b0;
      msk[k] = (k < N) ? jtag_pkg::INTERNAL_MASK[N-1-k] : 1'b0;
    end
    shift_dr(N);
    chk("captured", sh_out & ~msk, exp_v & ~msk);
    chk("first out", sh_out[0], pad_in[jtag_pkg::IDX_MDIO_OE]);
    chk("last out", sh_out[N-1], pad_in[jtag_pkg::IDX_INTERRUPT]);
    load_ir(jtag_pkg::INSTR_EXTEST);
    chk("extest pads", pad_out, pre_pat & ~jtag_pkg::INTERNAL_MASK);
    for (int i = 0; i < 5; i++) cyc(1'b1, 1'b0);
    repeat (8) @(posedge sys_clk);
    chk("tms reset", active_instr, jtag_pkg::INSTR_BYPASS);
    cyc(1'b0, 1'b0);
    chk("pads back", pad_out, core_pad_out & ~jtag_pkg::INTERNAL_MASK);
  endtask
  initial begin
    for (int i = 0; i < N; i++) begin
      pad_in[i] = i[0] ^ i[2];
      pre_pat[i] = i[1] ^ i[3];
    end
    core_pad_out = ~pre_pat;
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("reset instr", active_instr, jtag_pkg::INSTR_BYPASS);
    chk("reset oe", tdo_oe, 1'b0);
    t_bypass();
    t_chain();
    complete_run();
  end
endmodule
`default_nettype wire
